// ===== core/lcr_bank.sv
// latched configuration snapshots and identification registers
// assumes refresh_pulse is a one-cycle strobe on clk and active buses are on clk
// What this block does
// - control snapshot bit 1 keeps overflow alert enable active before last refresh.
// - control snapshot bit 0 keeps overflow flag as it stood before refresh.
// - every refresh variant copies active channel disables into the latched copy.
// - channel disable bits 7..4 map channels 1..4; one means skipped.
// - channel disable bits 3..0 always read zero.
// - snapshots are valid with results, 1 ms after a refresh.
// - every refresh copies active bidirectional range settings into the latched copy.
// - programmed disable and range values stay pending until a refresh.
// - range bits 7..4 pick signed sense range per channel 1..4.
// - range bits 3..0 pick signed bus voltage range per channel 1..4.
// - snapshots describe the configuration of the readable result dataset.
// - product register returns fixed code for two, three or four channels.
// - maker register returns a fixed maker code.
// - revision register returns a fixed die revision code.
// - refresh copies active control to snapshot, then activates programmed control.
`timescale 1ns/1ps
`default_nettype none
module lcr_bank
  import lcr_pkg::*;
(
  input wire logic clk, // 25 MHz device clock
  input wire logic nrst, // async power-on reset, active low
  input wire logic refresh_pulse, // one-cycle refresh, any variant
  input wire logic [7:0] prog_control, // programmed control settings
  input wire logic [7:0] prog_channel_disable, // programmed channel disables
  input wire logic [7:0] prog_bidirectional_range, // programmed range selections
  input wire logic [1:0] variant_sel, // channel count variant
  input wire logic reg_rd, // register read strobe
  input wire logic reg_wr, // register write strobe, only raises reg_hit
  input wire logic [7:0] reg_addr, // register address
  input wire logic [7:0] reg_wdata, // write data, ignored here
  output logic [7:0] reg_rdata, // registered read data
  output logic reg_hit, // address belongs to this bank
  output logic [7:0] active_control_settings, // control now in force
  output logic [7:0] active_channel_disable, // channel disables in force
  output logic [7:0] active_bidirectional_range, // ranges in force
  output logic [7:0] latched_control_snapshot, // control before last refresh
  output logic [7:0] latched_channel_disable, // disables before last refresh
  output logic [7:0] latched_bidirectional_range, // ranges before last refresh
  output logic [LCR_CHAN_COUNT-1:0] channel_skip_bit, // channel n skipped
  output logic [LCR_CHAN_COUNT-1:0] sense_signed_range_bit, // signed sense range
  output logic [LCR_CHAN_COUNT-1:0] bus_signed_range_bit, // signed bus range
  output logic overflow_alert_enable, // latched overflow alert enable
  output logic overflow_flag, // latched overflow flag
  output logic snapshot_valid // snapshots match readable results
);
  lcr_state_t state_reg;
  logic [$clog2(LCR_VALID_CYCLES+1)-1:0] wait_reg;
  logic [7:0] product_code_field;
  logic [7:0] maker_code;
  logic [7:0] revision_code_field;
  logic [7:0] rdata_next;
  logic hit_next;
  localparam logic [$clog2(LCR_VALID_CYCLES+1)-1:0] WAIT_LAST =
    ($clog2(LCR_VALID_CYCLES+1))'(LCR_VALID_CYCLES - 1);

  function automatic logic bank_decode(input logic [7:0] a);
    bank_decode = (a == LCR_OFS_LATCHED_CONTROL_SNAPSHOT) || (a == LCR_OFS_LATCHED_CHANNEL_DISABLE) ||
                  (a == LCR_OFS_RANGE_LAT) || (a == LCR_OFS_PRODUCT) ||
                  (a == LCR_OFS_MAKER) || (a == LCR_OFS_REVISION);
  endfunction

  lcr_id_rom u_id (
    .variant_sel(variant_sel),
    .product_code_field(product_code_field),
    .maker_code(maker_code),
    .revision_code_field(revision_code_field)
  );

  // the snapshot samples the old active value in the same edge that loads the new
  // one, so nothing programmed after the refresh can leak into it
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      latched_control_snapshot <= LCR_RST_SNAPSHOT;
      latched_channel_disable <= LCR_RST_SNAPSHOT;
      latched_bidirectional_range <= LCR_RST_SNAPSHOT;
    end else if (refresh_pulse) begin
      latched_control_snapshot <= active_control_settings;
      latched_channel_disable <= active_channel_disable & LCR_DIS_USED_MASK;
      latched_bidirectional_range <= active_bidirectional_range;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      active_control_settings <= LCR_RST_SNAPSHOT;
      active_channel_disable <= LCR_RST_SNAPSHOT;
      active_bidirectional_range <= LCR_RST_SNAPSHOT;
    end else if (refresh_pulse) begin
      active_control_settings <= prog_control;
      active_channel_disable <= prog_channel_disable & LCR_DIS_USED_MASK;
      active_bidirectional_range <= prog_bidirectional_range;
    end
  end

  // validity window after refresh; a new refresh restarts the wait
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      state_reg <= LCR_ST_VALID;
      wait_reg <= '0;
    end else begin
      case (state_reg)
        LCR_ST_VALID: begin
          if (refresh_pulse) begin
            state_reg <= LCR_ST_SETTLE;
            wait_reg <= '0;
          end
        end
        LCR_ST_SETTLE: begin
          if (refresh_pulse) begin
            wait_reg <= '0;
          end else if (wait_reg == WAIT_LAST) begin
            state_reg <= LCR_ST_VALID;
          end else begin
            wait_reg <= wait_reg + 1'b1;
          end
        end
        default: begin
          state_reg <= LCR_ST_VALID;
          wait_reg <= '0;
        end
      endcase
    end
  end
  assign snapshot_valid = (state_reg == LCR_ST_VALID);

  generate
    for (genvar i = 0; i < LCR_CHAN_COUNT; i++) begin : g_chan
      // channel 1 sits at the top bit of each field
      assign channel_skip_bit[i] =
        latched_channel_disable[LCR_POS_SKIP_LSB + LCR_CHAN_COUNT - 1 - i];
      assign sense_signed_range_bit[i] =
        latched_bidirectional_range[LCR_POS_SENSE_LSB + LCR_CHAN_COUNT - 1 - i];
      assign bus_signed_range_bit[i] =
        latched_bidirectional_range[LCR_POS_BUS_LSB + LCR_CHAN_COUNT - 1 - i];
    end
  endgenerate
  assign overflow_alert_enable = latched_control_snapshot[LCR_POS_OVERFLOW_ALERT_ENABLE];
  assign overflow_flag = latched_control_snapshot[LCR_POS_OVF_FLAG];

  always_comb begin
    hit_next = bank_decode(reg_addr);
    case (reg_addr)
      LCR_OFS_LATCHED_CONTROL_SNAPSHOT: rdata_next = latched_control_snapshot;
      LCR_OFS_LATCHED_CHANNEL_DISABLE: rdata_next = latched_channel_disable & LCR_DIS_USED_MASK;
      LCR_OFS_RANGE_LAT: rdata_next = latched_bidirectional_range;
      LCR_OFS_PRODUCT: rdata_next = product_code_field;
      LCR_OFS_MAKER: rdata_next = maker_code;
      LCR_OFS_REVISION: rdata_next = revision_code_field;
      default: rdata_next = LCR_READ_ZERO;
    endcase
  end

  // writes never reach any storage here; reg_wr only raises reg_hit on a bank address and reg_wdata is dropped
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      reg_rdata <= LCR_READ_ZERO;
      reg_hit <= 1'b0;
    end else begin
      reg_hit <= (reg_rd || reg_wr) && hit_next;
      if (reg_rd) begin
        reg_rdata <= rdata_next;
      end
    end
  end

  logic unused_wr;
  assign unused_wr = ^reg_wdata;
endmodule
`default_nettype wire

// ===== include/lcr_pkg.sv
// package for the latched configuration and identification register bank
// assumes an 8-bit register address and 8-bit read data from the serial front end
package lcr_pkg;
  localparam logic [7:0] LCR_OFS_LATCHED_CONTROL_SNAPSHOT = 8'h24;
  localparam logic [7:0] LCR_OFS_LATCHED_CHANNEL_DISABLE = 8'h25;
  localparam logic [7:0] LCR_OFS_RANGE_LAT = 8'h26;
  localparam logic [7:0] LCR_OFS_PRODUCT = 8'hFD;
  localparam logic [7:0] LCR_OFS_MAKER = 8'hFE;
  localparam logic [7:0] LCR_OFS_REVISION = 8'hFF;
  localparam int LCR_POS_OVF_FLAG = 0;
  localparam int LCR_POS_OVERFLOW_ALERT_ENABLE = 1;
  localparam int LCR_CHAN_COUNT = 4;
  localparam int LCR_POS_SKIP_LSB = 4;
  localparam int LCR_POS_SENSE_LSB = 4;
  localparam int LCR_POS_BUS_LSB = 0;
  localparam logic [7:0] LCR_RST_SNAPSHOT = 8'h00;
  localparam logic [7:0] LCR_DIS_USED_MASK = 8'hF0;
  localparam logic [7:0] LCR_READ_ZERO = 8'h00;
  // identification codes below are arbitrary neutral values
  localparam logic [7:0] LCR_ID_PRODUCT_2CH = 8'hA2;
  localparam logic [7:0] LCR_ID_PRODUCT_3CH = 8'hA3;
  localparam logic [7:0] LCR_ID_PRODUCT_4CH = 8'hA4;
  localparam logic [7:0] LCR_ID_MAKER = 8'hC7;
  localparam logic [7:0] LCR_ID_REVISION = 8'h01;
  // results and snapshots become valid this long after a refresh
  localparam int LCR_VALID_DELAY_US = 1000;
  localparam int LCR_CLK_MHZ = 25;
  localparam int LCR_VALID_CYCLES = LCR_VALID_DELAY_US * LCR_CLK_MHZ;
  typedef enum logic [1:0] {
    LCR_ST_VALID = 2'b01,
    LCR_ST_SETTLE = 2'b10
  } lcr_state_t;
endpackage

// ===== core/lcr_id_rom.sv
// fixed identification codes for the register bank
// assumes the variant select is static strap-like wiring
`timescale 1ns/1ps
`default_nettype none
module lcr_id_rom
  import lcr_pkg::*;
(
  input wire logic [1:0] variant_sel, // 0: two, 1: three, 2/3: four channels
  output logic [7:0] product_code_field, // product code
  output logic [7:0] maker_code, // maker code
  output logic [7:0] revision_code_field // die revision code
);
  always_comb begin
    case (variant_sel)
      2'h0: product_code_field = LCR_ID_PRODUCT_2CH;
      2'h1: product_code_field = LCR_ID_PRODUCT_3CH;
      default: product_code_field = LCR_ID_PRODUCT_4CH;
    endcase
  end
  assign maker_code = LCR_ID_MAKER;
  assign revision_code_field = LCR_ID_REVISION;
endmodule
`default_nettype wire

// ===== verification/lcr_bank_properties.sv
// checker for the latched register bank, bound onto lcr_bank
// assumes one clock domain and a registered read path
`timescale 1ns/1ps
`default_nettype none
module lcr_bank_chk
  import lcr_pkg::*;
(
  input wire logic clk, // clock
  input wire logic nrst, // reset
  input wire logic refresh_pulse, // refresh
  input wire logic [7:0] prog_channel_disable, // pending
  input wire logic reg_rd, // read
  input wire logic [7:0] reg_addr, // address
  input wire logic [7:0] reg_rdata, // read data
  input wire logic [7:0] active_control_settings, // active
  input wire logic [7:0] active_channel_disable, // active
  input wire logic [7:0] active_bidirectional_range, // active
  input wire logic [7:0] latched_control_snapshot, // latched
  input wire logic [7:0] latched_channel_disable, // latched
  input wire logic [7:0] latched_bidirectional_range, // latched
  input wire logic [LCR_CHAN_COUNT-1:0] channel_skip_bit, // decoded
  input wire logic overflow_flag, // decoded
  input wire logic overflow_alert_enable, // decoded
  input wire logic snapshot_valid // valid
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);
  AST_SNAP_CTRL: assert property (
    refresh_pulse |=> latched_control_snapshot == $past(active_control_settings))
    else $error("control snapshot not taken");
  AST_SNAP_DIS: assert property (
    refresh_pulse |=> latched_channel_disable == $past(active_channel_disable))
    else $error("disable snapshot not taken");
  AST_SNAP_RNG: assert property (
    refresh_pulse |=> latched_bidirectional_range == $past(active_bidirectional_range))
    else $error("range snapshot not taken");
  AST_ACTIVATE: assert property (
    refresh_pulse |=> active_channel_disable == ($past(prog_channel_disable) & 8'hF0))
    else $error("pending disables not activated");
  AST_PENDING: assert property (
    !refresh_pulse |=> $stable(active_bidirectional_range) && $stable(latched_bidirectional_range))
    else $error("range changed without refresh");
  AST_LOW_ZERO: assert property (latched_channel_disable[3:0] == 4'h0)
    else $error("unused disable bits set");
  AST_SKIP_MAP: assert property (
    channel_skip_bit == {latched_channel_disable[4], latched_channel_disable[5],
    latched_channel_disable[6], latched_channel_disable[7]})
    else $error("channel skip order wrong");
  AST_OVF_BITS: assert property (
    overflow_flag == latched_control_snapshot[0]
    && overflow_alert_enable == latched_control_snapshot[1])
    else $error("overflow bits misplaced");
  AST_WAIT: assert property (refresh_pulse |=> !snapshot_valid [*8])
    else $error("valid too early after refresh");
  AST_MAKER: assert property (
    reg_rd && reg_addr == LCR_OFS_MAKER |=> reg_rdata == LCR_ID_MAKER)
    else $error("maker code wrong");
  AST_READ_DIS: assert property (
    reg_rd && reg_addr == LCR_OFS_LATCHED_CHANNEL_DISABLE |=> reg_rdata == $past(latched_channel_disable))
    else $error("disable read mismatch");
endmodule
bind lcr_bank lcr_bank_chk chk_u (
  .clk(clk),
  .nrst(nrst),
  .refresh_pulse(refresh_pulse),
  .prog_channel_disable(prog_channel_disable),
  .reg_rd(reg_rd),
  .reg_addr(reg_addr),
  .reg_rdata(reg_rdata),
  .active_control_settings(active_control_settings),
  .active_channel_disable(active_channel_disable),
  .active_bidirectional_range(active_bidirectional_range),
  .latched_control_snapshot(latched_control_snapshot),
  .latched_channel_disable(latched_channel_disable),
  .latched_bidirectional_range(latched_bidirectional_range),
  .channel_skip_bit(channel_skip_bit),
  .overflow_flag(overflow_flag),
  .overflow_alert_enable(overflow_alert_enable),
  .snapshot_valid(snapshot_valid)
);
`default_nettype wire

// ===== verification/lcr_host_model.sv
// host model issuing single-byte register reads and writes
// assumes the bank answers one cycle after the reading edge
`timescale 1ns/1ps
`default_nettype none
module lcr_host_model (
  input wire logic clk, // clock
  input wire logic [7:0] reg_rdata, // read data
  input wire logic reg_hit, // hit flag
  output var logic reg_rd = 1'b0, // read strobe
  output var logic reg_wr = 1'b0, // write strobe
  output var logic [7:0] reg_addr = 8'h00, // address
  output var logic [7:0] reg_wdata = 8'h00 // write data
);
  task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic h);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    // inverse on release so a stale address never looks held
    reg_addr <= ~a;
    #1;
    d = reg_rdata;
    h = reg_hit;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= v;
    @(posedge clk);
    reg_wr <= 1'b0;
    reg_addr <= ~a;
    reg_wdata <= ~v;
  endtask
endmodule
`default_nettype wire

// ===== verification/lcr_bank_tb.sv
// self-checking bench for the latched register bank
// assumes the host model drives the register strobes
`timescale 1ns/1ps
`default_nettype none
module lcr_bank_tb
  import lcr_pkg::*;
;
  logic clk = 1'b0, nrst = 1'b0, refresh_pulse = 1'b0, reg_rd, reg_wr, reg_hit, h, ovf, alrt, vld;
  logic [7:0] pc = 8'h00, pd = 8'h00, pr = 8'h00, reg_addr, reg_wdata, reg_rdata, d, ad, ac, ar;
  logic [1:0] variant_sel = 2'h2;
  logic [3:0] skip, sns, bsr;
  int n_fail = 0, samples_checked = 0, cyc = 0;
  always #20 clk = ~clk;
  lcr_host_model host_u (.clk(clk), .reg_rdata(reg_rdata), .reg_hit(reg_hit), .reg_rd(reg_rd),
    .reg_wr(reg_wr), .reg_addr(reg_addr), .reg_wdata(reg_wdata));
  lcr_bank dut_u (.clk(clk), .nrst(nrst), .refresh_pulse(refresh_pulse), .prog_control(pc),
    .prog_channel_disable(pd), .prog_bidirectional_range(pr), .variant_sel(variant_sel),
    .reg_rd(reg_rd), .reg_wr(reg_wr), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata), .reg_hit(reg_hit), .active_control_settings(ac),
    .active_channel_disable(ad), .active_bidirectional_range(ar), .latched_control_snapshot(),
    .latched_channel_disable(), .latched_bidirectional_range(), .channel_skip_bit(skip),
    .sense_signed_range_bit(sns), .bus_signed_range_bit(bsr), .overflow_alert_enable(alrt),
    .overflow_flag(ovf), .snapshot_valid(vld));
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_fail++;
      $display("ERROR %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
    host_u.rd(a, d, h);
    chk(d, exp);
  endtask
  task automatic refresh(input logic [7:0] c, input logic [7:0] s, input logic [7:0] r);
    @(posedge clk);
    {pc, pd, pr} <= {c, s, r};
    refresh_pulse <= 1'b1;
    @(posedge clk);
    refresh_pulse <= 1'b0;
    #1;
  endtask
  task automatic t_ids;
    for (int v = 0; v < 4; v++) begin
      @(posedge clk);
      variant_sel <= 2'(v);
      rd_chk(LCR_OFS_PRODUCT,
        v == 0 ? LCR_ID_PRODUCT_2CH : v == 1 ? LCR_ID_PRODUCT_3CH : LCR_ID_PRODUCT_4CH);
    end
    rd_chk(LCR_OFS_REVISION, LCR_ID_REVISION);
    chk({7'h00, h}, 8'h01);
    rd_chk(8'h30, 8'h00);
    chk({7'h00, h}, 8'h00);
  endtask
  task automatic t_snap;
    refresh(8'h03, 8'hAF, 8'h5A);
    rd_chk(LCR_OFS_LATCHED_CONTROL_SNAPSHOT, 8'h00);
    @(posedge clk);
    pd <= 8'h5F;
    repeat (3) @(posedge clk);
    #1 chk(ad, 8'hA0);
    refresh(8'h02, 8'h5F, 8'hC3);
    rd_chk(LCR_OFS_LATCHED_CONTROL_SNAPSHOT, 8'h03);
    rd_chk(LCR_OFS_LATCHED_CHANNEL_DISABLE, 8'hA0);
    rd_chk(LCR_OFS_RANGE_LAT, 8'h5A);
    chk({6'h00, alrt, ovf}, 8'h03);
    chk({4'h0, skip}, 8'h05);
    chk({sns, bsr}, 8'hA5);
    chk(ac, 8'h02);
    chk(ar, 8'hC3);
  endtask
  // a mid-run reset must drop a pending settle wait and clear the active disables and the control snapshot
  task automatic t_reset;
    @(posedge clk);
    nrst <= 1'b0;
    @(posedge clk);
    #1 chk(ad, LCR_RST_SNAPSHOT);
    chk({7'h00, vld}, 8'h01);
    @(posedge clk);
    nrst <= 1'b1;
    rd_chk(LCR_OFS_LATCHED_CONTROL_SNAPSHOT, LCR_RST_SNAPSHOT);
  endtask
  task automatic t_write;
    host_u.wr(LCR_OFS_LATCHED_CHANNEL_DISABLE, 8'hFF);
    host_u.wr(LCR_OFS_MAKER, 8'h00);
    rd_chk(LCR_OFS_LATCHED_CHANNEL_DISABLE, 8'hA0);
    rd_chk(LCR_OFS_MAKER, LCR_ID_MAKER);
  endtask
  task automatic t_valid;
    refresh(8'h02, 8'h5F, 8'hC3);
    repeat (100) @(posedge clk);
    refresh(8'h02, 8'h5F, 8'hC3);
    // valid returns at the refresh edge plus the full count, so look one edge before it
    repeat (LCR_VALID_CYCLES - 1) @(posedge clk);
    #1 chk({7'h00, vld}, 8'h00);
    @(posedge clk);
    #1 chk({7'h00, vld}, 8'h01);
    rd_chk(LCR_OFS_LATCHED_CHANNEL_DISABLE, 8'h50);
  endtask
  task automatic end_sim;
    $display("checked %0d failed %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  // ceiling covers one full settle wait plus short traffic
  always @(posedge clk) begin
    cyc++;
    if (cyc == 40000) begin
      n_fail++;
      end_sim();
    end
  end
  initial begin
    repeat (10) @(posedge clk);
    nrst <= 1'b1;
    t_ids();
    t_snap();
    t_write();
    t_reset();
    t_valid();
    end_sim();
  end
endmodule
`default_nettype wire
